// *** hw/smp_parser.sv ***
// Character-stream program message parser with command tree tracking
module smp_parser (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Received character stream
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic end_line_flag,
   // Calibration access and status control
   input wire logic [31:0] cal_code,
   input wire logic err_clear,
   // Decoded message units
   output logic unit_valid,
   output logic [4:0] unit_node,
   output logic unit_query,
   output logic unit_param,
   output logic unit_numeric,
   output logic [31:0] unit_value,
   // Message and status
   output logic msg_done,
   output logic cmd_error,
   output logic cal_mode,
   output logic [4:0] tree_level
);

   smp_pkg::smp_state_t state_q, state_d;
   smp_pkg::smp_word_t key_q, key_d, key_a, lk_key;
   logic [3:0] klen_q, klen_d, klen_a, lk_len;
   logic [4:0] node_q, node_d, lvl_d, hit_node, emit_node;
   logic pend_q, pend_d, query_q, query_d, start_q, start_d;
   logic pany_q, pany_d, pnum_q, pnum_d;
   logic [31:0] pval_q, pval_d;
   logic [7:0] ch;
   logic is_nl, ordinary, is_digit, term, hit;
   logic emit, emit_query, emit_param, emit_num, err, done;
   logic [31:0] emit_val;
   logic cal_hit, cal_ok, cal_exit, cal_refuse;

   // Character classification; case is folded before every comparison except the newline test
   assign ch = smp_pkg::smp_upcase(rx_data);
   assign is_nl = (rx_data == smp_pkg::CHR_NL);
   assign term = rx_valid && (is_nl || end_line_flag);
   assign ordinary = !(is_nl || ch == smp_pkg::CHR_COLON || ch == smp_pkg::CHR_SEMI ||
                       ch == smp_pkg::CHR_QMARK || ch == smp_pkg::CHR_SPACE);
   assign is_digit = (ch >= smp_pkg::CHR_ZERO) && (ch <= smp_pkg::CHR_NINE);

   // Keyword as it stands after this character, so an end-of-line character still counts
   assign key_a = {key_q[87:0], ch};
   assign klen_a = klen_q + 4'h1;
   assign lk_key = ordinary ? key_a : key_q;
   assign lk_len = ordinary ? klen_a : klen_q;

   // Search of the current level; the source level is also searched from the root
   always_comb begin
      hit = 1'b0;
      hit_node = smp_pkg::NODE_ROOT;
      for (int i = 0; i < smp_pkg::KW_COUNT; i++) begin
         if (!hit && (smp_pkg::KW_PARENT[i] == tree_level ||
             (tree_level == smp_pkg::NODE_ROOT && smp_pkg::KW_PARENT[i] == smp_pkg::NODE_SOURCE)) &&
             smp_pkg::smp_kw_match(lk_key, lk_len, smp_pkg::KW_TEXT[i], smp_pkg::KW_LEN[i])) begin
            hit = 1'b1;
            hit_node = 5'(i + 1);
         end
      end
   end

   // Parse sequencer: one character per valid cycle, no stall needed
   always_comb begin
      state_d = state_q;
      key_d = key_q;
      klen_d = klen_q;
      lvl_d = tree_level;
      node_d = node_q;
      pend_d = pend_q;
      query_d = query_q;
      start_d = start_q;
      pany_d = pany_q;
      pnum_d = pnum_q;
      pval_d = pval_q;
      emit = 1'b0;
      emit_node = node_q;
      emit_query = query_q;
      emit_num = pnum_q;
      emit_val = pval_q;
      err = 1'b0;
      done = 1'b0;
      if (rx_valid) begin
         unique case (state_q)
            smp_pkg::SMP_KEY: begin
               if (ordinary && (pend_q || klen_q == smp_pkg::KW_CHARS)) begin
                  err = 1'b1;
               end else if (ordinary) begin
                  key_d = key_a;
                  klen_d = klen_a;
                  start_d = 1'b0;
               end
               if (!err && (!ordinary || end_line_flag)) begin
                  if (term || ch == smp_pkg::CHR_SEMI) begin
                     // Unit closes here; after a semicolon the level is kept for the next unit
                     if (lk_len != 4'h0) begin
                        if (hit) begin
                           emit = 1'b1;
                           emit_node = hit_node;
                           emit_query = 1'b0;
                        end else begin
                           err = 1'b1;
                        end
                     end else if (pend_q) begin
                        emit = 1'b1;
                        emit_query = 1'b1;
                     end
                     start_d = 1'b1;
                  end else if (ch == smp_pkg::CHR_COLON) begin
                     if (klen_q != 4'h0) begin
                        if (hit) begin
                           lvl_d = hit_node;
                        end else begin
                           err = 1'b1;
                        end
                     end else if (pend_q) begin
                        query_d = 1'b0;
                     end else if (start_q) begin
                        lvl_d = smp_pkg::NODE_ROOT;
                     end else begin
                        err = 1'b1;
                     end
                  end else if (ch == smp_pkg::CHR_QMARK) begin
                     if (klen_q != 4'h0 && hit) begin
                        node_d = hit_node;
                        query_d = 1'b1;
                     end else begin
                        err = 1'b1;
                     end
                  end else if (klen_q != 4'h0) begin
                     // Space after a keyword opens the parameter
                     if (hit) begin
                        node_d = hit_node;
                        query_d = 1'b0;
                        state_d = smp_pkg::SMP_PARAM;
                     end else begin
                        err = 1'b1;
                     end
                  end else if (pend_q) begin
                     state_d = smp_pkg::SMP_PARAM;
                  end
                  pend_d = (ch == smp_pkg::CHR_QMARK) && !term;
                  key_d = '0;
                  klen_d = 4'h0;
               end
            end
            smp_pkg::SMP_PARAM: begin
               if (ordinary) begin
                  pany_d = 1'b1;
                  if (is_digit) begin
                     pval_d = 32'(pval_q * smp_pkg::DEC_BASE + {24'h0, ch - smp_pkg::CHR_ZERO});
                  end else if (ch != smp_pkg::CHR_DOT && ch != smp_pkg::CHR_PLUS && ch != smp_pkg::CHR_MINUS) begin
                     pnum_d = 1'b0;
                  end
               end
               if (term || ch == smp_pkg::CHR_SEMI) begin
                  emit = 1'b1;
                  start_d = 1'b1;
                  state_d = smp_pkg::SMP_KEY;
               end else if ((ch == smp_pkg::CHR_SPACE && pany_q) || ch == smp_pkg::CHR_COLON ||
                            ch == smp_pkg::CHR_QMARK) begin
                  err = 1'b1;
               end
            end
            smp_pkg::SMP_SKIP: begin
               // Rest of a bad unit is dropped up to the next semicolon or terminator
               if (ch == smp_pkg::CHR_SEMI) begin
                  state_d = smp_pkg::SMP_KEY;
                  start_d = 1'b1;
               end
            end
         endcase
         if (err) begin
            state_d = smp_pkg::SMP_SKIP;
            emit = 1'b0;
         end
         if (emit || err || (state_q == smp_pkg::SMP_SKIP && ch == smp_pkg::CHR_SEMI)) begin
            pend_d = 1'b0;
            query_d = 1'b0;
            key_d = '0;
            klen_d = 4'h0;
         end
         if (term) begin
            // Only here does a message close
            done = 1'b1;
            lvl_d = smp_pkg::NODE_ROOT;
            state_d = smp_pkg::SMP_KEY;
            start_d = 1'b1;
            pend_d = 1'b0;
            query_d = 1'b0;
            key_d = '0;
            klen_d = 4'h0;
         end
         // Parameter as it closes, taken before the accumulator is cleared for the next unit
         emit_num = pnum_d;
         emit_val = pval_d;
         if (state_d != smp_pkg::SMP_PARAM) begin
            pany_d = 1'b0;
            pnum_d = 1'b1;
            pval_d = 32'h0;
         end
      end
   end

   assign emit_param = (state_q == smp_pkg::SMP_PARAM) && (pany_q || (ordinary && rx_valid));

   // Keyword assembly and unit context
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_q <= smp_pkg::SMP_KEY;
         key_q <= '0;
         klen_q <= 4'h0;
         node_q <= smp_pkg::NODE_ROOT;
         pend_q <= 1'b0;
         query_q <= 1'b0;
         start_q <= 1'b1;
      end else begin
         state_q <= state_d;
         key_q <= key_d;
         klen_q <= klen_d;
         node_q <= node_d;
         pend_q <= pend_d;
         query_q <= query_d;
         start_q <= start_d;
      end
   end

   // Parameter accumulation; numeric values wrap silently beyond 32 bits
   always_ff @(posedge clock) begin
      if (!resetn) begin
         pany_q <= 1'b0;
         pnum_q <= 1'b1;
         pval_q <= 32'h0;
      end else begin
         pany_q <= pany_d;
         pnum_q <= pnum_d;
         pval_q <= pval_d;
      end
   end

   // Tree position
   always_ff @(posedge clock) begin
      if (!resetn) begin
         tree_level <= smp_pkg::NODE_ROOT;
      end else begin
         tree_level <= lvl_d;
      end
   end

   // Unit hand-off to the command executor
   always_ff @(posedge clock) begin
      if (!resetn) begin
         unit_valid <= 1'b0;
         unit_node <= smp_pkg::NODE_ROOT;
         unit_query <= 1'b0;
         unit_param <= 1'b0;
         unit_numeric <= 1'b0;
         unit_value <= 32'h0;
         msg_done <= 1'b0;
      end else begin
         unit_valid <= emit;
         msg_done <= done;
         if (emit) begin
            unit_node <= emit_node;
            unit_query <= emit_query;
            unit_param <= emit_param;
            unit_numeric <= emit_param && emit_num;
            unit_value <= emit_val;
         end
      end
   end

   // Calibration gate: zero leaves, the access code enters, anything else is refused
   assign cal_hit = emit && emit_node == smp_pkg::NODE_CAL_STATE && !emit_query && emit_param;
   assign cal_exit = cal_hit && emit_num && emit_val == 32'h0;
   assign cal_ok = cal_hit && emit_num && emit_val == cal_code && !cal_exit;
   assign cal_refuse = cal_hit && !cal_exit && !cal_ok;

   always_ff @(posedge clock) begin
      if (!resetn) begin
         cal_mode <= 1'b0;
      end else if (cal_ok) begin
         cal_mode <= 1'b1;
      end else if (cal_exit) begin
         cal_mode <= 1'b0;
      end
   end

   // Sticky error; a new error in the clear cycle wins
   always_ff @(posedge clock) begin
      if (!resetn) begin
         cmd_error <= 1'b0;
      end else if (err || cal_refuse) begin
         cmd_error <= 1'b1;
      end else if (err_clear) begin
         cmd_error <= 1'b0;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence s_query_mark;
      rx_valid && state_q == smp_pkg::SMP_KEY && ch == smp_pkg::CHR_QMARK && !end_line_flag && klen_q != 4'h0 &&
      hit && !pend_q;
   endsequence
   sequence s_plain_semi;
      rx_valid && ch == smp_pkg::CHR_SEMI && !end_line_flag;
   endsequence
   sequence s_plain_colon;
      rx_valid && ch == smp_pkg::CHR_COLON && !end_line_flag;
   endsequence

   query_unit_a: assert property (s_query_mark ##1 s_plain_semi |=> unit_valid && unit_query &&
      unit_node == $past(hit_node, 2)) else $error("query unit not emitted");
   query_sibling_a: assert property (s_query_mark ##1 s_plain_colon |=> !pend_q &&
      tree_level == $past(tree_level, 2)) else $error("level moved after query colon");
   term_root_a: assert property (term |=> tree_level == smp_pkg::NODE_ROOT && msg_done)
      else $error("terminator did not return to root");
   eol_close_a: assert property (rx_valid && end_line_flag && !is_nl |=> msg_done && state_q == smp_pkg::SMP_KEY)
      else $error("end-of-line character did not close message");
   done_cause_a: assert property (msg_done |-> $past(term)) else $error("message closed without terminator");
   root_colon_a: assert property (s_plain_colon and (state_q == smp_pkg::SMP_KEY && start_q && klen_q == 4'h0 &&
      !pend_q) |=> tree_level == smp_pkg::NODE_ROOT) else $error("root colon ignored");
   descend_a: assert property (s_plain_colon and (state_q == smp_pkg::SMP_KEY && klen_q != 4'h0 && hit) |=>
      tree_level == $past(hit_node)) else $error("separator did not descend");
   unit_split_a: assert property (s_plain_semi and (state_q == smp_pkg::SMP_KEY && klen_q != 4'h0 && hit) |=>
      unit_valid && !unit_query ##1 !unit_valid [*1]) else $error("semicolon did not split unit");
   miss_error_a: assert property (rx_valid && state_q == smp_pkg::SMP_KEY && !ordinary && klen_q != 4'h0 && !hit
      |=> cmd_error && state_q != smp_pkg::SMP_PARAM) else $error("bad keyword not flagged");
   cal_gate_a: assert property (!cal_mode ##1 cal_mode |-> unit_valid && $past(emit_val, 1) == $past(cal_code, 1))
      else $error("calibration entered without code");

endmodule : smp_parser

// *** shared/smp_pkg.sv ***
// Constants, keyword tree and helper functions for the command message parser
package smp_pkg;

   // Character codes
   localparam logic [7:0] CHR_NL = 8'h0a;
   localparam logic [7:0] CHR_SPACE = 8'h20;
   localparam logic [7:0] CHR_PLUS = 8'h2b;
   localparam logic [7:0] CHR_MINUS = 8'h2d;
   localparam logic [7:0] CHR_DOT = 8'h2e;
   localparam logic [7:0] CHR_ZERO = 8'h30;
   localparam logic [7:0] CHR_NINE = 8'h39;
   localparam logic [7:0] CHR_COLON = 8'h3a;
   localparam logic [7:0] CHR_SEMI = 8'h3b;
   localparam logic [7:0] CHR_QMARK = 8'h3f;
   localparam logic [7:0] CHR_LOW_A = 8'h61;
   localparam logic [7:0] CHR_LOW_Z = 8'h7a;
   localparam logic [7:0] CASE_OFFSET = 8'h20;

   // Keyword store geometry and short-form limits
   localparam logic [3:0] KW_CHARS = 4'hc;
   localparam int KW_COUNT = 31;
   localparam logic [3:0] SHORT_LONG = 4'h4;
   localparam logic [3:0] SHORT_VOWEL = 4'h3;
   localparam logic [31:0] DEC_BASE = 32'h0000000a;

   // Tree nodes: root is zero, node n is table entry n-1
   localparam logic [4:0] NODE_ROOT = 5'h00;
   localparam logic [4:0] NODE_SOURCE = 5'h08;
   localparam logic [4:0] NODE_CAL_STATE = 5'h1a;

   typedef enum logic [2:0] {SMP_KEY = 3'b001, SMP_PARAM = 3'b010, SMP_SKIP = 3'b100} smp_state_t;
   typedef logic [95:0] smp_word_t;

   // Long forms, right aligned, upper case
   localparam smp_word_t KW_TEXT [KW_COUNT] = '{
      96'("ABORT"), 96'("CALIBRATE"), 96'("DISPLAY"), 96'("INITIATE"), 96'("LIST"),
      96'("MEASURE"), 96'("OUTPUT"), 96'("SOURCE"), 96'("STATUS"), 96'("SYSTEM"),
      96'("TRIGGER"), 96'("VOLTAGE"), 96'("CURRENT"), 96'("FUNCTION"), 96'("OPERATION"),
      96'("PRESET"), 96'("QUESTIONABLE"), 96'("CONDITION"), 96'("ENABLE"), 96'("EVENT"),
      96'("CONDITION"), 96'("ENABLE"), 96'("EVENT"), 96'("LEVEL"), 96'("LEVEL"),
      96'("STATE"), 96'("VOLTAGE"), 96'("CURRENT"), 96'("ERROR"), 96'("IMMEDIATE"),
      96'("IMMEDIATE")};
   localparam logic [3:0] KW_LEN [KW_COUNT] = '{
      4'h5, 4'h9, 4'h7, 4'h8, 4'h4, 4'h7, 4'h6, 4'h6, 4'h6, 4'h6,
      4'h7, 4'h7, 4'h7, 4'h8, 4'h9, 4'h6, 4'hc, 4'h9, 4'h6, 4'h5,
      4'h9, 4'h6, 4'h5, 4'h5, 4'h5, 4'h5, 4'h7, 4'h7, 4'h5, 4'h9,
      4'h9};
   localparam logic [4:0] KW_PARENT [KW_COUNT] = '{
      5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00,
      5'h00, 5'h08, 5'h08, 5'h08, 5'h09, 5'h09, 5'h09, 5'h0f, 5'h0f, 5'h0f,
      5'h11, 5'h11, 5'h11, 5'h0c, 5'h0d, 5'h02, 5'h06, 5'h06, 5'h0a, 5'h18,
      5'h19};

   // Folds lower-case letters onto upper case
   function automatic logic [7:0] smp_upcase(input logic [7:0] c);
      if (c >= CHR_LOW_A && c <= CHR_LOW_Z) begin
         return c - CASE_OFFSET;
      end
      return c;
   endfunction : smp_upcase

   // Length of the short form of a long-form keyword
   function automatic logic [3:0] smp_short_len(input smp_word_t word, input logic [3:0] wlen);
      smp_word_t sh;
      logic [7:0] c4;
      if (wlen <= SHORT_LONG) begin
         return wlen;
      end
      sh = word >> (8 * (wlen - SHORT_LONG));
      c4 = sh[7:0];
      if (c4 == "A" || c4 == "E" || c4 == "I" || c4 == "O" || c4 == "U") begin
         return SHORT_VOWEL;
      end
      return SHORT_LONG;
   endfunction : smp_short_len

   // Accepts only the exact short form or the exact long form
   function automatic logic smp_kw_match(input smp_word_t key, input logic [3:0] klen, input smp_word_t word,
                                         input logic [3:0] wlen);
      logic [3:0] s;
      s = smp_short_len(word, wlen);
      return (klen == wlen && key == word) || (klen == s && key == (word >> (8 * (wlen - s))));
   endfunction : smp_kw_match

endpackage : smp_pkg

// *** tb/smp_host.sv ***
// Host controller model that streams program message characters into the parser
module smp_host (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Character stream toward the parser
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic end_line_flag
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle line at time zero
   initial begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
      end_line_flag = 1'b0;
   end

   // Sends one message; term 0 leaves it open, 1 appends a newline, 2 flags the last character
   task automatic send(input string m, input int term, input int gap);
      string s;
      s = (term == 1) ? {m, "\n"} : m;
      // Waits at most 16 cycles for the parser to leave reset before sending
      for (int w = 0; w < 16 && resetn !== 1'b1; w++) begin
         @(posedge clock);
      end
      for (int i = 0; i < s.len(); i++) begin
         @(posedge clock);
         rx_data <= s[i];
         rx_valid <= 1'b1;
         end_line_flag <= (term == 2) && (i == s.len() - 1);
         // Slow host: the idle byte is flipped so a stale character never looks valid
         repeat (gap) begin
            @(posedge clock);
            rx_valid <= 1'b0;
            end_line_flag <= 1'b0;
            rx_data <= ~s[i];
         end
      end
      @(posedge clock);
      rx_valid <= 1'b0;
      end_line_flag <= 1'b0;
      rx_data <= ~rx_data;
   endtask : send
endmodule : smp_host

// *** tb/smp_parser_tb.sv ***
// Self-checking testbench for the program message parser
module smp_parser_tb;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {logic [4:0] node; logic query; logic param; logic numeric; logic [31:0] value;} smp_exp_t;

   logic clock;
   logic resetn;
   logic err_clear;
   logic [31:0] cal_code;
   logic [7:0] rx_data;
   logic rx_valid;
   logic end_line_flag;
   logic unit_valid;
   logic unit_query;
   logic unit_param;
   logic unit_numeric;
   logic msg_done;
   logic cmd_error;
   logic cal_mode;
   logic [4:0] unit_node;
   logic [4:0] tree_level;
   logic [31:0] unit_value;
   smp_exp_t exp_q[$];
   int fail_count = 0;
   int n_tests = 0;
   int msgs_seen = 0;
   int msgs_exp = 0;
   bit ignore_units = 1'b0;
   int seed = 24018;
   int v;
   string roots_s[11] = '{"ABOR", "CAL", "DISP", "INIT", "LIST", "MEAS", "OUTP", "SOUR", "STAT", "SYST", "TRIG"};
   string roots_l[11] = '{"abort", "Calibrate", "DISPLAY", "initiate", "List", "measure", "OutPut", "source",
                          "sTaTuS", "system", "TRIGGER"};
   string bad[9] = '{"VOLT:LEV:IMME", "STAT:OPER:ENABL", "LIS", "OUTPU 1", "STAT:FOO", "STAT:QUESTIONABLEX",
                     "FUNC?X", "VOLT 1 2", "VOLT 1:2"};

   // 250 MHz system clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   smp_parser dut_u (.clock(clock), .resetn(resetn), .rx_data(rx_data), .rx_valid(rx_valid),
      .end_line_flag(end_line_flag), .cal_code(cal_code), .err_clear(err_clear), .unit_valid(unit_valid),
      .unit_node(unit_node), .unit_query(unit_query), .unit_param(unit_param), .unit_numeric(unit_numeric),
      .unit_value(unit_value), .msg_done(msg_done), .cmd_error(cmd_error), .cal_mode(cal_mode),
      .tree_level(tree_level));

   smp_host host_u (.clock(clock), .resetn(resetn), .rx_data(rx_data), .rx_valid(rx_valid),
      .end_line_flag(end_line_flag));

   // Prints the counts and the verdict, then ends the run
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   // Compares one flag
   task automatic chk_bit(input logic got, input logic want, input string what);
      n_tests++;
      if (got !== want) begin
         fail_count++;
         $display("MISMATCH at %0t: %s got %b want %b", $time, what, got, want);
      end
   endtask : chk_bit

   // Compares one decoded unit; kind only matters when a parameter came with it, value only when it was numeric
   task automatic chk_unit(input smp_exp_t got, input smp_exp_t want);
      n_tests++;
      if (got.node !== want.node || got.query !== want.query || got.param !== want.param ||
          (want.param && got.numeric !== want.numeric) || (want.numeric && got.value !== want.value)) begin
         fail_count++;
         $display("MISMATCH at %0t: unit got %h want %h", $time, got, want);
      end
   endtask : chk_unit

   // Notes one expected unit
   task automatic eu(input logic [4:0] n, input logic q, input logic p, input logic nm, input logic [31:0] val);
      smp_exp_t e;
      e = '{n, q, p, nm, val};
      exp_q.push_back(e);
   endtask : eu

   // Sends a message, then checks the error flag, and for a closed message the tree position, once the answer has landed
   task automatic run(input string m, input int term, input logic err);
      host_u.send(m, term, $unsigned($random(seed)) % 2);
      if (term != 0) msgs_exp++;
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk_bit(cmd_error, err, "command error");
      if (term != 0) chk_bit(tree_level === 5'h00, 1'b1, "tree at root");
      @(posedge clock);
      err_clear <= 1'b1;
      @(posedge clock);
      err_clear <= 1'b0;
   endtask : run

   // Output watcher: every decoded unit retires the oldest note unless ignore_units is set
   always @(negedge clock) begin
      if (resetn === 1'b1 && msg_done === 1'b1) msgs_seen++;
      if (resetn === 1'b1 && unit_valid === 1'b1 && !ignore_units) begin
         if (exp_q.size() == 0) chk_bit(1'b1, 1'b0, "unexpected unit");
         else chk_unit({unit_node, unit_query, unit_param, unit_numeric, unit_value}, exp_q.pop_front());
      end
   end

   // Hang guard well above the longest sequence
   initial begin
      repeat (50000) @(posedge clock);
      fail_count++;
      close_out();
   end

   // Main sequence
   initial begin
      resetn = 1'b0;
      err_clear = 1'b0;
      cal_code = 32'h00000000;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      cal_code <= ($random(seed) & 32'h7ffffe00) | 32'h00000101;
      @(negedge clock);
      chk_bit(cal_mode, 1'b0, "cal mode after reset");
      for (int i = 0; i < 11; i++) begin
         eu(5'(i + 1), 1'b0, 1'b0, 1'b0, 32'h0);
         run(roots_s[i], 1, 1'b0);
         eu(5'(i + 1), 1'b0, 1'b0, 1'b0, 32'h0);
         run(roots_l[i], 1, 1'b0);
      end
      for (int i = 0; i < 3; i++) begin
         v = $unsigned($random(seed)) % 100000;
         eu(5'h0c, 1'b0, 1'b1, 1'b1, v);
         run($sformatf("VOLT %0d", v), 1, 1'b0);
      end
      eu(5'h07, 1'b0, 1'b1, 1'b0, 32'h0);
      run("OUTP ON", 1, 1'b0);
      eu(5'h0e, 1'b1, 1'b0, 1'b0, 32'h0);
      run("FUNC?", 1, 1'b0);
      eu(5'h10, 1'b0, 1'b0, 1'b0, 32'h0);
      run("STAT:OPER?:PRES", 1, 1'b0);
      eu(5'h1b, 1'b1, 1'b0, 1'b0, 32'h0);
      eu(5'h1c, 1'b1, 1'b0, 1'b0, 32'h0);
      run("meas:volt?;curr?", 1, 1'b0);
      eu(5'h12, 1'b1, 1'b0, 1'b0, 32'h0);
      eu(5'h13, 1'b0, 1'b1, 1'b1, 32'h10);
      run("STAT:OPER:COND?;ENAB 16", 1, 1'b0);
      eu(5'h19, 1'b0, 1'b1, 1'b1, 32'hf);
      eu(5'h18, 1'b0, 1'b1, 1'b1, 32'h6);
      run(":CURR:LEV 15;:VOLT:LEVel 6", 1, 1'b0);
      eu(5'h18, 1'b0, 1'b1, 1'b1, 32'h6);
      run("VOLT:LEV 6;CURR:LEV 15", 1, 1'b1);
      eu(5'h1d, 1'b1, 1'b0, 1'b0, 32'h0);
      run("SYST:ERR?", 1, 1'b0);
      eu(5'h11, 1'b1, 1'b0, 1'b0, 32'h0);
      run("stat:ques?", 1, 1'b0);
      eu(5'h1e, 1'b0, 1'b0, 1'b0, 32'h0);
      run("VOLT:LEV:IMM", 1, 1'b0);
      for (int i = 0; i < 9; i++) run(bad[i], 1, 1'b1);
      eu(5'h07, 1'b0, 1'b1, 1'b1, 32'h1);
      host_u.send("OUTP 1", 0, 0);
      repeat (6) @(posedge clock);
      @(negedge clock);
      chk_bit(exp_q.size() == 1 && msgs_seen == msgs_exp, 1'b1, "open message held");
      run("", 1, 1'b0);
      eu(5'h0b, 1'b0, 1'b0, 1'b0, 32'h0);
      run("TRIG", 2, 1'b0);
      // A refused code still echoes its unit, but units are not noted for it
      ignore_units = 1'b1;
      run("CAL:STAT 123", 1, 1'b1);
      ignore_units = 1'b0;
      chk_bit(cal_mode, 1'b0, "cal mode refused");
      eu(5'h1a, 1'b0, 1'b1, 1'b1, cal_code);
      run($sformatf("CAL:STAT %0d", cal_code), 1, 1'b0);
      chk_bit(cal_mode, 1'b1, "cal mode entered");
      eu(5'h1a, 1'b0, 1'b1, 1'b1, 32'h0);
      run("CAL:STAT 0", 1, 1'b0);
      chk_bit(cal_mode, 1'b0, "cal mode left");
      chk_bit(msgs_seen == msgs_exp, 1'b1, "message count");
      chk_bit(exp_q.size() == 0, 1'b1, "units outstanding");
      close_out();
   end
endmodule : smp_parser_tb
